// file: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  logic rise_reg;
  wire agree = (ff2_reg == ff3_reg);

  // Three-stage chain; level moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ff1_reg <= 1'b0;
      ff2_reg <= 1'b0;
      ff3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      ff1_reg <= pin_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      if (agree)
        level_reg <= ff3_reg;
      rise_reg <= agree & ff3_reg & ~level_reg;
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;
endmodule : pin_sync

// file: logic/tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 12,
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_tick,
  output logic out_tick
);
  logic [W-1:0] count_reg;
  logic out_reg;
  wire last = (count_reg == W'(DIV - 1));

  // One output tick for every DIV input ticks
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= '0;
      out_reg <= 1'b0;
    end
    else
    begin
      out_reg <= in_tick & last;
      if (in_tick)
        count_reg <= last ? '0 : count_reg + W'(1);
    end
  end

  assign out_tick = out_reg;
endmodule : tick_divider

// file: logic/timer3_pkg.sv
package timer3_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] count_t;
  // Clock source of one counter half
  typedef enum logic [1:0] {SRC_SYSTEM_CLOCK, SRC_DIV12, SRC_EXT8} clk_src_t;
endpackage : timer3_pkg

// file: logic/timer3_regs.svh
`ifndef TIMER3_REGS_SVH
`define TIMER3_REGS_SVH

// Register byte offsets on the bus
`define OFS_CONTROL 8'h00
`define OFS_RELOAD_LOW 8'h04
`define OFS_RELOAD_HIGH 8'h08
`define OFS_COUNT_LOW 8'h0c
`define OFS_COUNT_HIGH 8'h10
`define OFS_CLOCK_SELECT 8'h14
`define OFS_IRQ_ENABLE 8'h18
`define OFS_STATUS 8'h1c

// Control register field positions
`define BIT_HIGH_OVERFLOW 7
`define BIT_LOW_OVERFLOW 6
`define BIT_LOW_IRQ_ENABLE 5
`define BIT_CAPTURE_ENABLE 4
`define BIT_SPLIT_MODE 3
`define BIT_RUN_CONTROL 2
`define BIT_EXTERNAL_CLOCK 0

// Clock select, interrupt enable and status field positions
`define BIT_LOW_SYSTEM_CLOCK 0
`define BIT_HIGH_SYSTEM_CLOCK 1
`define BIT_TIMER_IRQ_ENABLE 0
`define BIT_SYNC_BUSY 0

// Reset values
`define RST_CONTROL 8'h00
`define RST_RELOAD 8'h00
`define RST_COUNT 8'h00
`define RST_CLOCK_SELECT 8'h00
`define RST_IRQ_ENABLE 8'h00

// Timing counts
`define SYSTEM_CLOCK_DIVIDE 12
`define EXTERNAL_DIVIDE 8
`define SYNC_BUSY_TICKS 2'd3

`endif

// file: logic/timer3_reload_capture.sv
// Summary of operation
// - Sixteen-bit counter of two bytes; split bit picks one 16-bit or two 8-bit.
// - Clock sources are system clock, system clock over 12, external over 8.
// - External tick is retimed to system clock except in suspend, where it drives directly.
// - In suspend the counter keeps counting on external ticks and high overflow wakes device.
// - After a foreign wake-up, busy flag stays set for three timer ticks.
// - Sixteen-bit rollover loads the reload pair and sets the high overflow flag.
// - Sixteen-bit mode requests an interrupt on each overflow when enabled.
// - With low-byte enable too, low byte rollover also requests an interrupt.
// - In split mode each half reloads from its own reload byte on overflow.
// - In split mode run control gates only the high half; low half always counts.
// - Each half picks its clock from its own select bit and the external select.
// - In split mode each half's rollover sets its own overflow flag.
// - Split mode interrupts on high overflow, or either half with low-byte enable.
// - Hardware never clears overflow flags; software clears them by writing zero.
// - Capture mode needs capture enable set and split clear; no external clock then.
// - Comparator rising edge copies count to reload pair and sets high overflow flag.
// - In 16-bit mode run control starts and stops the whole counter.
`timescale 1ns/1ps
`include "timer3_regs.svh"
module timer3_reload_capture (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_osc_in,
  input wire logic comparator0_in,
  input wire logic suspend_in,
  input wire logic wake_other_in,
  output logic irq_req,
  output logic wake_req,
  output logic sync_busy
);
  timer3_pkg::byte_t control_reg;
  timer3_pkg::byte_t reload_low_byte_reg;
  timer3_pkg::byte_t reload_high_byte_reg;
  timer3_pkg::count_t count_reg;
  timer3_pkg::count_t count_next;
  timer3_pkg::byte_t clock_select_reg;
  timer3_pkg::byte_t irq_enable_reg;
  logic [1:0] busy_count_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic wake_reg;
  logic ext_sync_reg;
  logic low_wrap;
  logic high_wrap;

  // Control fields
  wire high_overflow_flag = control_reg[`BIT_HIGH_OVERFLOW];
  wire low_overflow_flag = control_reg[`BIT_LOW_OVERFLOW];
  wire low_byte_irq_enable = control_reg[`BIT_LOW_IRQ_ENABLE];
  wire comparator_capture_enable = control_reg[`BIT_CAPTURE_ENABLE];
  wire split_mode_select = control_reg[`BIT_SPLIT_MODE];
  wire run_control = control_reg[`BIT_RUN_CONTROL];
  wire external_clock_select = control_reg[`BIT_EXTERNAL_CLOCK];
  wire low_half_system_clock_select = clock_select_reg[`BIT_LOW_SYSTEM_CLOCK];
  wire high_half_system_clock_select = clock_select_reg[`BIT_HIGH_SYSTEM_CLOCK];
  wire timer_irq_enable = irq_enable_reg[`BIT_TIMER_IRQ_ENABLE];
  wire sync_busy_flag = (busy_count_reg != 2'd0);

  // Capture only applies in 16-bit mode
  wire capture_mode = comparator_capture_enable & ~split_mode_select;

  // Bus decode; a write lands on the edge where ack is seen high
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  wire wr_control = bus_wr & (wb_adr_i == `OFS_CONTROL);
  wire wr_reload_low = bus_wr & (wb_adr_i == `OFS_RELOAD_LOW);
  wire wr_reload_high = bus_wr & (wb_adr_i == `OFS_RELOAD_HIGH);
  wire wr_count_low = bus_wr & (wb_adr_i == `OFS_COUNT_LOW) & ~sync_busy_flag;
  wire wr_count_high = bus_wr & (wb_adr_i == `OFS_COUNT_HIGH) & ~sync_busy_flag;
  wire wr_clock_select = bus_wr & (wb_adr_i == `OFS_CLOCK_SELECT);
  wire wr_irq_enable = bus_wr & (wb_adr_i == `OFS_IRQ_ENABLE);
  wire [7:0] wr_byte = wb_dat_i[7:0];

  // Read selection; unmapped offsets read zero
  wire [7:0] status_byte = {7'h00, sync_busy_flag};
  wire [7:0] read_byte =
    (wb_adr_i == `OFS_CONTROL) ? control_reg :
    (wb_adr_i == `OFS_RELOAD_LOW) ? reload_low_byte_reg :
    (wb_adr_i == `OFS_RELOAD_HIGH) ? reload_high_byte_reg :
    (wb_adr_i == `OFS_COUNT_LOW) ? count_reg[7:0] :
    (wb_adr_i == `OFS_COUNT_HIGH) ? count_reg[15:8] :
    (wb_adr_i == `OFS_CLOCK_SELECT) ? clock_select_reg :
    (wb_adr_i == `OFS_IRQ_ENABLE) ? irq_enable_reg :
    (wb_adr_i == `OFS_STATUS) ? status_byte : 8'h00;

  // Pin synchronisers for the oscillator and the comparator
  logic ext_rise;
  logic cmp_rise;
  pin_sync u_ext_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(ext_osc_in),
    .level(),
    .rise(ext_rise)
  );
  pin_sync u_cmp_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(comparator0_in),
    .level(),
    .rise(cmp_rise)
  );

  // Prescalers; the divide by 12 stops with the system clock in suspend
  logic div12_tick;
  logic ext_raw_tick;
  tick_divider #(.DIV(`SYSTEM_CLOCK_DIVIDE), .W(4)) u_div12 (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_tick(~suspend_in),
    .out_tick(div12_tick)
  );
  tick_divider #(.DIV(`EXTERNAL_DIVIDE), .W(3)) u_div8 (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_tick(ext_rise),
    .out_tick(ext_raw_tick)
  );

  // Retimed external tick normally, raw tick while suspended
  wire ext_tick = suspend_in ? ext_raw_tick : ext_sync_reg;

  // Per-half clock choice: index 0 is the low half, 1 the high half
  wire [1:0] half_system_clock_select = {high_half_system_clock_select, low_half_system_clock_select};
  logic [1:0] half_tick;
  genvar h;
  generate
    for (h = 0; h < 2; h++)
    begin : g_half_clock
      timer3_pkg::clk_src_t src;
      assign src = half_system_clock_select[h] ? timer3_pkg::SRC_SYSTEM_CLOCK :
        (external_clock_select & ~capture_mode) ? timer3_pkg::SRC_EXT8 :
        timer3_pkg::SRC_DIV12;
      assign half_tick[h] = (src == timer3_pkg::SRC_SYSTEM_CLOCK) ? ~suspend_in :
        (src == timer3_pkg::SRC_EXT8) ? ext_tick : div12_tick;
    end
  endgenerate

  // Counter next value, reload on rollover, wrap events
  always_comb
  begin
    count_next = count_reg;
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    if (!split_mode_select)
    begin
      if (run_control & half_tick[0])
      begin
        low_wrap = (count_reg[7:0] == 8'hff);
        if (count_reg == 16'hffff)
        begin
          count_next = {reload_high_byte_reg, reload_low_byte_reg};
          high_wrap = 1'b1;
        end
        else
          count_next = count_reg + 16'h0001;
      end
    end
    else
    begin
      if (half_tick[0])
      begin
        low_wrap = (count_reg[7:0] == 8'hff);
        count_next[7:0] = low_wrap ? reload_low_byte_reg : count_reg[7:0] + 8'h01;
      end
      if (run_control & half_tick[1])
      begin
        high_wrap = (count_reg[15:8] == 8'hff);
        count_next[15:8] = high_wrap ? reload_high_byte_reg : count_reg[15:8] + 8'h01;
      end
    end
    if (wr_count_low)
      count_next[7:0] = wr_byte;
    if (wr_count_high)
      count_next[15:8] = wr_byte;
  end

  // Flag updates; a hardware set wins over a software clear
  wire capture_event = capture_mode & cmp_rise;
  wire high_set = high_wrap | capture_event;
  wire [7:0] control_wr = wr_control ? {wr_byte[7:2], 1'b0, wr_byte[0]} : control_reg;
  wire [7:0] control_next = {
    control_wr[7] | high_set,
    control_wr[6] | low_wrap,
    control_wr[5:0]
  };

  // Control, counter and clock select registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control_reg <= `RST_CONTROL;
      count_reg <= {`RST_COUNT, `RST_COUNT};
      clock_select_reg <= `RST_CLOCK_SELECT;
      irq_enable_reg <= `RST_IRQ_ENABLE;
    end
    else
    begin
      control_reg <= control_next;
      count_reg <= count_next;
      if (wr_clock_select)
        clock_select_reg <= {6'h00, wr_byte[1:0]};
      if (wr_irq_enable)
        irq_enable_reg <= {7'h00, wr_byte[0]};
    end
  end

  // Reload pair; a capture takes priority over a software write
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reload_low_byte_reg <= `RST_RELOAD;
      reload_high_byte_reg <= `RST_RELOAD;
    end
    else if (capture_event)
    begin
      reload_low_byte_reg <= count_reg[7:0];
      reload_high_byte_reg <= count_reg[15:8];
    end
    else
    begin
      if (wr_reload_low)
        reload_low_byte_reg <= wr_byte;
      if (wr_reload_high)
        reload_high_byte_reg <= wr_byte;
    end
  end

  // Busy window after a wake-up from another source, counted in timer ticks
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      busy_count_reg <= 2'd0;
    else if (wake_other_in)
      busy_count_reg <= `SYNC_BUSY_TICKS;
    else if (sync_busy_flag & half_tick[0])
      busy_count_reg <= busy_count_reg - 2'd1;
  end

  // External tick retiming and wake pulse on overflow during suspend
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_sync_reg <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      ext_sync_reg <= ext_raw_tick;
      wake_reg <= suspend_in & high_wrap;
    end
  end

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg)
        dat_reg <= {24'h00_0000, read_byte};
    end
  end

  // Interrupt request from the sticky flags
  assign irq_req = timer_irq_enable &
    (high_overflow_flag | (low_byte_irq_enable & low_overflow_flag));
  assign wake_req = wake_reg;
  assign sync_busy = sync_busy_flag;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
endmodule : timer3_reload_capture

// file: verif/test_timer3_reload_capture.sv
`timescale 1ns/1ps
`include "timer3_regs.svh"
module test_timer3_reload_capture;
  logic core_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, ext_osc_in = 0, comparator0_in = 0, suspend_in = 0, wake_other_in = 0;
  logic irq_req, wake_req, sync_busy, seen;
  int miscompares = 0, compares = 0, n;
  timer3_pkg::byte_t rd, lo;
  timer3_pkg::count_t cap1;
  // Clock and device under test
  always #4 core_clk = ~core_clk;
  timer3_reload_capture timer3_reload_capture_inst (.core_clk(core_clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_osc_in(ext_osc_in), .comparator0_in(comparator0_in), .suspend_in(suspend_in),
    .wake_other_in(wake_other_in), .irq_req(irq_req), .wake_req(wake_req),
    .sync_busy(sync_busy));
  task results;
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One classic bus cycle, entered right after a clock edge
  task wb(input logic [7:0] adr, input logic we, input logic [7:0] wd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      results();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task wr(input logic [7:0] adr, input logic [7:0] wd);
    wb(adr, 1'b1, wd);
  endtask : wr
  task rchk(input logic [7:0] adr, input logic [7:0] exp);
    wb(adr, 1'b0, 8'h00);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rchk
  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rchk(`OFS_CONTROL, 8'h00);
    rchk(`OFS_COUNT_HIGH, 8'h00);
    rchk(8'h20, 8'h00);
    wr(`OFS_CLOCK_SELECT, 8'h01);
    wr(`OFS_IRQ_ENABLE, 8'h01);
    wr(`OFS_RELOAD_LOW, 8'h34);
    wr(`OFS_RELOAD_HIGH, 8'h12);
    wr(`OFS_COUNT_LOW, 8'hf0);
    wr(`OFS_COUNT_HIGH, 8'hff);
    wr(`OFS_CONTROL, 8'h04);
    repeat (30) @(posedge core_clk);
    rchk(`OFS_CONTROL, 8'hc4);
    check({15'h0, irq_req}, 16'h1);
    wr(`OFS_CONTROL, 8'hc0);
    repeat (20) @(posedge core_clk);
    rchk(`OFS_CONTROL, 8'hc0);
    rchk(`OFS_COUNT_HIGH, 8'h12);
    // A stopped counter must hold its low byte between two reads
    wb(`OFS_COUNT_LOW, 1'b0, 8'h00);
    lo = rd;
    repeat (10) @(posedge core_clk);
    rchk(`OFS_COUNT_LOW, lo);
    wr(`OFS_CONTROL, 8'h00);
    check({15'h0, irq_req}, 16'h0);
    wr(`OFS_COUNT_LOW, 8'hf0);
    wr(`OFS_COUNT_HIGH, 8'h00);
    wr(`OFS_CONTROL, 8'h24);
    repeat (30) @(posedge core_clk);
    rchk(`OFS_CONTROL, 8'h64);
    check({15'h0, irq_req}, 16'h1);
    wr(`OFS_CONTROL, 8'h00);
    // Split halves: low runs alone, then both
    wr(`OFS_CLOCK_SELECT, 8'h03);
    wr(`OFS_RELOAD_LOW, 8'ha0);
    wr(`OFS_RELOAD_HIGH, 8'h55);
    wr(`OFS_COUNT_HIGH, 8'h10);
    wr(`OFS_COUNT_LOW, 8'hf0);
    wr(`OFS_CONTROL, 8'h08);
    repeat (30) @(posedge core_clk);
    rchk(`OFS_CONTROL, 8'h48);
    check({15'h0, irq_req}, 16'h0);
    rchk(`OFS_COUNT_HIGH, 8'h10);
    wr(`OFS_CONTROL, 8'h2c);
    repeat (300) @(posedge core_clk);
    rchk(`OFS_CONTROL, 8'hec);
    check({15'h0, irq_req}, 16'h1);
    wr(`OFS_CONTROL, 8'h00);
    // Capture two comparator edges exactly 100 cycles apart
    wr(`OFS_CLOCK_SELECT, 8'h01);
    wr(`OFS_COUNT_HIGH, 8'h00);
    wr(`OFS_COUNT_LOW, 8'h00);
    wr(`OFS_CONTROL, 8'h14);
    fork
      begin
        comparator0_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        comparator0_in <= 1'b0;
        repeat (96) @(posedge core_clk);
        comparator0_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        comparator0_in <= 1'b0;
      end
      begin
        repeat (20) @(posedge core_clk);
        wb(`OFS_RELOAD_LOW, 1'b0, 8'h00);
        lo = rd;
        wb(`OFS_RELOAD_HIGH, 1'b0, 8'h00);
        cap1 = {rd, lo};
        repeat (100) @(posedge core_clk);
      end
    join
    wb(`OFS_RELOAD_LOW, 1'b0, 8'h00);
    lo = rd;
    wb(`OFS_RELOAD_HIGH, 1'b0, 8'h00);
    check({rd, lo} - cap1, 16'd100);
    rchk(`OFS_CONTROL, 8'h94);
    check({15'h0, irq_req}, 16'h1);
    // Foreign wake opens a busy window of three slow ticks
    wr(`OFS_CLOCK_SELECT, 8'h00);
    wr(`OFS_CONTROL, 8'h08);
    wake_other_in <= 1'b1;
    @(posedge core_clk);
    wake_other_in <= 1'b0;
    @(posedge core_clk);
    check({15'h0, sync_busy}, 16'h1);
    repeat (20) @(posedge core_clk);
    check({15'h0, sync_busy}, 16'h1);
    for (n = 0; n < 60 && sync_busy !== 1'b0; n++)
      @(posedge core_clk);
    check({15'h0, sync_busy}, 16'h0);
    rchk(`OFS_STATUS, 8'h00);
    // Suspended counter wraps on external ticks and wakes
    wr(`OFS_CONTROL, 8'h05);
    wr(`OFS_COUNT_LOW, 8'hff);
    wr(`OFS_COUNT_HIGH, 8'hff);
    suspend_in <= 1'b1;
    seen = 1'b0;
    for (n = 0; n < 96; n++)
    begin
      ext_osc_in <= n[2];
      @(posedge core_clk);
      if (wake_req === 1'b1)
        seen = 1'b1;
    end
    suspend_in <= 1'b0;
    check({15'h0, seen}, 16'h1);
    rchk(`OFS_CONTROL, 8'hc5);
    results();
  end
endmodule : test_timer3_reload_capture

// file: verif/timer3_monitor.sv
`timescale 1ns/1ps
module timer3_monitor (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ext_osc_in,
  input wire logic comparator0_in,
  input wire logic suspend_in,
  input wire logic wake_other_in,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic sync_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Bus answers once, one cycle after the request is taken
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h1c
    |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  // Wake pulse only from a suspended counter
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  a_wake_suspend: assert property (wake_req |-> suspend_in || $past(suspend_in))
    else $error("wake request outside suspend");
  // Busy window opens on a foreign wake only
  a_busy_set: assert property (wake_other_in |=> sync_busy)
    else $error("busy not set after foreign wake");
  a_busy_cause: assert property ($rose(sync_busy) |-> $past(wake_other_in))
    else $error("busy set without foreign wake");
  // Hardware never drops a request: only a register write may
  a_irq_fall_write: assert property ($fell(irq_req) |-> $past(wb_cyc_i && wb_we_i))
    else $error("interrupt request dropped without write");
endmodule : timer3_monitor
bind timer3_reload_capture timer3_monitor timer3_monitor_inst (.core_clk(core_clk),
  .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ext_osc_in(ext_osc_in), .comparator0_in(comparator0_in),
  .suspend_in(suspend_in), .wake_other_in(wake_other_in), .irq_req(irq_req),
  .wake_req(wake_req), .sync_busy(sync_busy));
